// ==== dv/tap_port_checker.sv ====
// port-level timing checker for the test port
`timescale 1ns/10ps
module tap_port_checker
#(
    parameter int USER_WIDTH = tap_pkg::USER_WIDTH
)
(
    input wire logic                  i_sys_clk,
    input wire logic                  i_srst,
    input wire logic                  i_tck,
    input wire logic                  i_tms,
    input wire logic                  i_tdi,
    input wire logic                  i_trst_n,
    input wire logic [USER_WIDTH-1:0] i_user_capture,
    input wire logic                  o_tdo,
    input wire logic                  o_tdo_oe_n,
    input wire logic [USER_WIDTH-1:0] o_user_update,
    input wire logic [3:0]            o_ir,
    input wire logic [3:0]            o_state
);
    // --------
    // properties
    // --------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst || !i_trst_n);
    // pin reset is async, so no disable here
    a_trst_clear:
        assert property (disable iff (1'b0) !i_trst_n |=> o_state == 4'h0 && o_tdo_oe_n
            && o_ir == tap_pkg::IR_IDENT && o_user_update == '0) else $error("trst no clear");
    a_srst_clear:
        assert property (disable iff (1'b0) i_srst |=> o_state == 4'h0 && o_tdo_oe_n
            && o_ir == tap_pkg::IR_IDENT) else $error("srst no clear");
    // driven only from shift states up to the following fall
    a_float_idle:
        assert property (!o_tdo_oe_n |-> o_state inside {4'd4, 4'd5, 4'd11, 4'd12})
        else $error("tdo driven outside shift");
    // sync lag lies within one tck phase
    a_step_rise:
        assert property ($changed(o_state) |-> $past(i_tck, 2) || $past(i_tck, 3)
            || $past(i_tck, 4)) else $error("state moved off rising tck");
    a_tdo_fall:
        assert property ($changed(o_tdo) |-> !$past(i_tck, 2) || !$past(i_tck, 3)
            || !$past(i_tck, 4)) else $error("tdo moved off falling tck");
    a_idle_exit:
        assert property ($past(o_state) == 4'd1 && o_state != 4'd1 |-> o_state == 4'd2)
        else $error("bad exit from idle");
    a_shift_exit:
        assert property ($past(o_state) == 4'd4 && o_state != 4'd4 |-> o_state == 4'd5)
        else $error("bad exit from shift dr");
    a_ir_update:
        assert property ($changed(o_ir) |-> $past(o_state) == 4'd15 || o_state == 4'd0)
        else $error("ir changed outside update");
    a_user_load:
        assert property ($changed(o_user_update) |-> $past(o_state) == 4'd8
            && $past(o_ir) == 4'h1) else $error("user reg changed outside update");
endmodule // tap_port_checker

bind tap_port tap_port_checker #(.USER_WIDTH(USER_WIDTH)) u_checker (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_tck(i_tck), .i_tms(i_tms),
    .i_tdi(i_tdi), .i_trst_n(i_trst_n), .i_user_capture(i_user_capture),
    .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_user_update(o_user_update),
    .o_ir(o_ir), .o_state(o_state)
);

// ==== dv/tap_tester.sv ====
// model of the external boundary-scan tester
`timescale 1ns/10ps
module tap_tester
(
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe_n,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n
);
    logic held;
    logic line;
    // --------
    // pins
    // --------
    // no pull on tdo, so a released line shows the inverse of its last value
    always @(i_tdo or i_tdo_oe_n) if (!i_tdo_oe_n) held = i_tdo;
    assign line = i_tdo_oe_n ? ~held : i_tdo;
    // tck rests low between frames
    initial
    begin
        held = 1'b0;
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
    end
    // one tck cycle, 48 ns, far below the allowed rate
    task cyc(input logic m, input logic d, output logic o);
        o_tms = m;
        o_tdi = d;
        #24 o_tck = 1'b1;
        o = line;
        #24 o_tck = 1'b0;
    endtask
    // test reset pulse, then settle time before the next edge
    task pulse();
        o_trst_n = 1'b0;
        #30 o_trst_n = 1'b1;
        #30;
    endtask
endmodule // tap_tester

// ==== dv/test_tap_port.sv ====
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module test_tap_port;
    logic        clk, srst, tck, tms, tdi, trst_n, tdo, oe_n;
    logic [7:0]  cap, upd;
    logic [3:0]  ir, st;
    logic [31:0] q;
    int          miscompares = 0, check_count = 0, cycles = 0;
    // --------
    // instances and clock
    // --------
    tap_port DUT (.i_sys_clk(clk), .i_srst(srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .i_user_capture(cap), .o_tdo(tdo), .o_tdo_oe_n(oe_n),
        .o_user_update(upd), .o_ir(ir), .o_state(st));
    tap_tester tester (.i_tdo(tdo), .i_tdo_oe_n(oe_n), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_n(trst_n));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard, far above the thousand or so cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    // --------
    // helpers
    // --------
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // capture, n shift bits with exit on the last, update, idle
    task scan(input logic irp, input logic [31:0] d, input int n, output logic [31:0] r);
        logic o;
        r = '0;
        tester.cyc(1'b1, ~d[0], o);
        if (irp) tester.cyc(1'b1, d[1], o);
        tester.cyc(1'b0, ~d[1], o);
        tester.cyc(1'b0, d[2], o);
        for (int i = 0; i < n; i++) tester.cyc(i == n - 1, d[i], r[i]);
        tester.cyc(1'b1, ~d[3], o);
        tester.cyc(1'b0, d[4], o);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // --------
    // scenarios
    // --------
    task t_ident();
        logic o;
        cmp(32'(ir), 32'(tap_pkg::IR_IDENT));
        cmp(32'(oe_n), 32'h1);
        repeat (5) tester.cyc(1'b1, 1'b1, o);
        tester.cyc(1'b0, 1'b0, o);
        cmp(32'(st), 32'h1);
        scan(1'b0, 32'hDEAD_BEEF, 32, q);
        cmp(q, tap_pkg::ID_VALUE);
        cmp(32'(oe_n), 32'h1);
        $display("t_ident done");
    endtask
    task t_user();
        @(posedge clk);
        #1 cap = 8'h3C;
        scan(1'b1, 32'h0000_0001, 4, q);
        cmp(q, 32'(tap_pkg::IR_CAPTURE));
        cmp(32'(ir), 32'h1);
        scan(1'b0, 32'h0000_00A5, 8, q);
        cmp(q, 32'h0000_003C);
        cmp(32'(upd), 32'h0000_00A5);
        $display("t_user done");
    endtask
    // one-bit path delays tdi by a single shift after a zero capture
    task t_bypass();
        scan(1'b1, 32'h0000_000F, 4, q);
        cmp(32'(ir), 32'hF);
        scan(1'b0, 32'h0000_00C3, 9, q);
        cmp(q, 32'h0000_0186);
        $display("t_bypass done");
    endtask
    // pause inside a bypass shift: bit held, line floats, no shift on the way back
    task t_pause();
        logic       o;
        logic [2:0] r;
        tester.cyc(1'b1, 1'b0, o);
        tester.cyc(1'b0, 1'b0, o);
        tester.cyc(1'b0, 1'b0, o);
        tester.cyc(1'b0, 1'b1, r[0]);
        tester.cyc(1'b1, 1'b1, r[1]);
        tester.cyc(1'b0, 1'b0, o);
        cmp(32'(st), 32'h6);
        cmp(32'(oe_n), 32'h1);
        tester.cyc(1'b1, 1'b0, o);
        tester.cyc(1'b0, 1'b0, o);
        // let the last fall pass the pin crossing before looking
        #20;
        cmp(32'(oe_n), 32'h0);
        tester.cyc(1'b1, 1'b0, r[2]);
        tester.cyc(1'b1, 1'b0, o);
        tester.cyc(1'b0, 1'b0, o);
        cmp(32'(r), 32'h6);
        cmp(32'(st), 32'h1);
        $display("t_pause done");
    endtask
    // test reset in the middle of an instruction shift
    task t_trst();
        logic o;
        tester.cyc(1'b1, 1'b0, o);
        tester.cyc(1'b1, 1'b1, o);
        tester.cyc(1'b0, 1'b0, o);
        tester.cyc(1'b0, 1'b1, o);
        tester.cyc(1'b0, 1'b0, o);
        tester.pulse();
        cmp(32'(st), 32'h0);
        cmp(32'(ir), 32'(tap_pkg::IR_IDENT));
        cmp(32'(upd), 32'h0);
        cmp(32'(oe_n), 32'h1);
        // controller must step again once the test reset is gone
        tester.cyc(1'b0, 1'b0, o);
        cmp(32'(st), 32'h1);
        $display("t_trst done");
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        srst = 1'b1;
        cap = 8'h00;
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        t_ident();
        t_user();
        t_bypass();
        t_pause();
        t_trst();
        print_verdict();
    end
endmodule // test_tap_port

// ==== rtl/tap_pin_sync.sv ====
// two-stage synchronisers and test clock edge finder
`timescale 1ns/10ps
module tap_pin_sync
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_srst,
    input  wire logic              i_tck,
    input  wire logic              i_tms,
    input  wire logic              i_tdi,
    output tap_pkg::link_in_s      o_link
);

    logic [2:0] meta;
    logic [2:0] sync;
    logic       tck_prev;
    logic [2:0] next_meta;
    logic [2:0] next_sync;
    logic       next_tck_prev;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // only the second stage is looked at; edges found on it
    always_comb
    begin
        next_meta     = {i_tck, i_tms, i_tdi};
        next_sync     = meta;
        next_tck_prev = sync[2];
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            meta     <= 3'h0;
            sync     <= 3'h0;
            tck_prev <= 1'b0;
        end
        else
        begin
            meta     <= next_meta;
            sync     <= next_sync;
            tck_prev <= next_tck_prev;
        end
    end

    // edges and levels for the tap logic
    assign o_link.tck_rise = sync[2] & ~tck_prev;
    assign o_link.tck_fall = ~sync[2] & tck_prev;
    assign o_link.tms      = sync[1];
    assign o_link.tdi      = sync[0];

endmodule // tap_pin_sync

// ==== rtl/tap_pkg.sv ====
// package of constants and carriers for the boundary-scan test port
package tap_pkg;

    // ------------------------------------------------------------
    // instruction and register widths, values after reset
    // ------------------------------------------------------------
    localparam int          IR_WIDTH     = 4;
    localparam logic [3:0]  IR_IDENT     = 4'h2;    // opcode 0010
    localparam logic [3:0]  IR_BYPASS    = 4'hF;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;    // ir capture pattern
    localparam int          ID_WIDTH     = 32;
    localparam int          USER_WIDTH   = 8;
    localparam int          SYNC_STAGES  = 2;
    // arbitrary identity value, not any real part
    localparam logic [31:0] ID_VALUE     = 32'h1234_5679;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAUSE_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR,
        ST_EX2_IR, ST_UPD_IR
    } tap_state_e;

    // sampled link pins after crossing
    typedef struct packed {
        logic tck_rise;
        logic tck_fall;
        logic tms;
        logic tdi;
    } link_in_s;

endpackage

// ==== rtl/tap_port.sv ====
// boundary-scan test port: tap controller, instruction and data registers
// Summary of operation
// RULE1: test data sampled on rising test clock
// RULE2: shift out lsb first on falling edge
// RULE3: output floats when not shifting
// RULE4: mode select sampled on rising edge
// RULE5: test reset clears, loads identify opcode
// RULE6: tester keeps test clock slow enough
// RULE7: standard sixteen-state tap controller
`timescale 1ns/10ps
module tap_port
#(
    parameter int USER_WIDTH = tap_pkg::USER_WIDTH
)
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_tck,
    input  wire logic                  i_tms,
    input  wire logic                  i_tdi,
    input  wire logic                  i_trst_n,
    input  wire logic [USER_WIDTH-1:0] i_user_capture,
    output logic                       o_tdo,
    output logic                       o_tdo_oe_n,
    output logic [USER_WIDTH-1:0]      o_user_update,
    output logic [3:0]                 o_ir,
    output logic [3:0]                 o_state
);

    // ------------------------------------------------------------
    // pin crossing
    // ------------------------------------------------------------
    tap_pkg::link_in_s link;
    logic              trst_meta;
    logic              trst_n_sync;

    // relies on the tester keeping the test clock slow: see RULE6
    tap_pin_sync u_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_tck     (i_tck),
        .i_tms     (i_tms),
        .i_tdi     (i_tdi),
        .o_link    (link)
    );

    // test reset: acts at once on its own, released through two flops
    always_ff @(posedge i_sys_clk or negedge i_trst_n)
    begin
        if (!i_trst_n)
        begin
            trst_meta   <= 1'b0;
            trst_n_sync <= 1'b0;
        end
        else
        begin
            trst_meta   <= 1'b1;
            trst_n_sync <= trst_meta;
        end
    end

    // ------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------
    tap_pkg::tap_state_e state;
    tap_pkg::tap_state_e next_state;

    // step on each rising test clock edge by sampled mode select
    always_comb
    begin
        next_state = state;
        if (link.tck_rise)                                   // see RULE4
        begin
            unique case (state)                              // see RULE7
                tap_pkg::ST_RESET:    next_state = link.tms ? tap_pkg::ST_RESET  : tap_pkg::ST_IDLE;
                tap_pkg::ST_IDLE:     next_state = link.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_DR:   next_state = link.tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
                tap_pkg::ST_CAP_DR:   next_state = link.tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_SH_DR:    next_state = link.tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_EX1_DR:   next_state = link.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
                tap_pkg::ST_PAUSE_DR: next_state = link.tms ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAUSE_DR;
                tap_pkg::ST_EX2_DR:   next_state = link.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_UPD_DR:   next_state = link.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_IR:   next_state = link.tms ? tap_pkg::ST_RESET  : tap_pkg::ST_CAP_IR;
                tap_pkg::ST_CAP_IR:   next_state = link.tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_SH_IR:    next_state = link.tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_EX1_IR:   next_state = link.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
                tap_pkg::ST_PAUSE_IR: next_state = link.tms ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAUSE_IR;
                tap_pkg::ST_EX2_IR:   next_state = link.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_UPD_IR:   next_state = link.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // shift paths and output
    // ------------------------------------------------------------
    logic [3:0]            ir;
    logic [3:0]            ir_sh;
    logic [31:0]           id_sh;
    logic                  byp_sh;
    logic [USER_WIDTH-1:0] usr_sh;
    logic [USER_WIDTH-1:0] usr_upd;
    logic                  tdo;
    logic                  tdo_oe_n;
    logic [3:0]            next_ir;
    logic [3:0]            next_ir_sh;
    logic [31:0]           next_id_sh;
    logic                  next_byp_sh;
    logic [USER_WIDTH-1:0] next_usr_sh;
    logic [USER_WIDTH-1:0] next_usr_upd;
    logic                  next_tdo;
    logic                  next_tdo_oe_n;

    // lsb of the path that the current instruction selects
    function automatic logic dr_lsb(input logic [3:0] op, input logic [31:0] id,
                                    input logic byp, input logic u);
        if (op == tap_pkg::IR_IDENT)
            dr_lsb = id[0];
        else if (op == tap_pkg::IR_CAPTURE)
            dr_lsb = u;
        else
            dr_lsb = byp;
    endfunction

    always_comb
    begin
        next_ir       = ir;
        next_ir_sh    = ir_sh;
        next_id_sh    = id_sh;
        next_byp_sh   = byp_sh;
        next_usr_sh   = usr_sh;
        next_usr_upd  = usr_upd;
        next_tdo      = tdo;
        next_tdo_oe_n = tdo_oe_n;
        // tdi only matters while a shift state is active
        if (link.tck_rise)
        begin
            unique case (state)
                tap_pkg::ST_RESET:
                    next_ir = tap_pkg::IR_IDENT;
                tap_pkg::ST_CAP_IR:
                    next_ir_sh = tap_pkg::IR_CAPTURE;
                tap_pkg::ST_SH_IR:
                    next_ir_sh = {link.tdi, ir_sh[3:1]};                   // see RULE1
                tap_pkg::ST_UPD_IR:
                    next_ir = ir_sh;
                tap_pkg::ST_CAP_DR:
                begin
                    next_id_sh  = tap_pkg::ID_VALUE;
                    next_byp_sh = 1'b0;
                    next_usr_sh = i_user_capture;
                end
                tap_pkg::ST_SH_DR:
                begin
                    if (ir == tap_pkg::IR_IDENT)
                        next_id_sh = {link.tdi, id_sh[31:1]};              // see RULE1
                    else if (ir == tap_pkg::IR_CAPTURE)
                        next_usr_sh = {link.tdi, usr_sh[USER_WIDTH-1:1]};
                    else
                        next_byp_sh = link.tdi;
                end
                tap_pkg::ST_UPD_DR:
                    if (ir == tap_pkg::IR_CAPTURE)
                        next_usr_upd = usr_sh;
                default:
                    next_ir = ir;
            endcase
        end
        // output changes only on the falling edge, lsb first
        if (link.tck_fall)
        begin
            if (state == tap_pkg::ST_SH_IR)
            begin
                next_tdo      = ir_sh[0];                                  // see RULE2
                next_tdo_oe_n = 1'b0;
            end
            else if (state == tap_pkg::ST_SH_DR)
            begin
                next_tdo      = dr_lsb(ir, id_sh, byp_sh, usr_sh[0]);      // see RULE2
                next_tdo_oe_n = 1'b0;
            end
            else
            begin
                next_tdo      = 1'b0;
                next_tdo_oe_n = 1'b1;                                      // see RULE3
            end
        end
    end

    // test reset wins over everything; system reset does the same
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || !trst_n_sync)
        begin
            state    <= tap_pkg::ST_RESET;                                 // see RULE5
            ir       <= tap_pkg::IR_IDENT;                                 // see RULE5
            ir_sh    <= 4'h0;
            id_sh    <= 32'h0000_0000;
            byp_sh   <= 1'b0;
            usr_sh   <= '0;
            usr_upd  <= '0;
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end
        else
        begin
            state    <= next_state;
            ir       <= next_ir;
            ir_sh    <= next_ir_sh;
            id_sh    <= next_id_sh;
            byp_sh   <= next_byp_sh;
            usr_sh   <= next_usr_sh;
            usr_upd  <= next_usr_upd;
            tdo      <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
        end
    end

    // outputs straight from flops
    assign o_tdo         = tdo;
    assign o_tdo_oe_n    = tdo_oe_n;
    assign o_user_update = usr_upd;
    assign o_ir          = ir;
    assign o_state       = state;

endmodule // tap_port
